// File: tecm_pkg.sv
package tecm_pkg;
   // register addresses on the parallel control port
   localparam logic [7:0] TECM_ADDR_LINE_HIGH = 8'h23;
   localparam logic [7:0] TECM_ADDR_LINE_LOW = 8'h24;
   localparam logic [7:0] TECM_ADDR_PATH_HIGH = 8'h25;
   localparam logic [7:0] TECM_ADDR_PATH_LOW = 8'h26;
   localparam logic [7:0] TECM_ADDR_EVENT_MASK = 8'h6F;
   localparam logic [7:0] TECM_ADDR_ALARM_MASK = 8'h7F;
   // reset values
   localparam logic [7:0] TECM_MASK_RESET = 8'h00;
   // counter widths
   localparam int TECM_LINE_WIDTH = 16;
   localparam int TECM_PATH_WIDTH = 12;
   // zero run lengths for excessive-zero detection
   localparam logic [4:0] TECM_ZERO_RUN_PLAIN = 5'h10;
   localparam logic [4:0] TECM_ZERO_RUN_B8ZS = 5'h08;
   // update interval selection
   typedef enum logic {TECM_ONE_SECOND, TECM_FAST_42MS} tecm_interval_type;
endpackage

// File: tecm_sat_counter.sv
`timescale 1ns/1ns
// saturating interval accumulator with snapshot register
module tecm_sat_counter
   import tecm_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic count_en,
   input wire logic update,
   output logic [WIDTH-1:0] snapshot
);
   logic [WIDTH-1:0] accum_reg; // running count of the open interval
   localparam logic [WIDTH-1:0] ALL_ONES = '1;
   localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

   // accumulate; an event in the update cycle opens the new interval at one
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         accum_reg <= '0;
      end
      else if (update)
      begin
         accum_reg <= count_en ? ONE : '0; // (R16)
      end
      else if (count_en && accum_reg != ALL_ONES)
      begin
         accum_reg <= accum_reg + ONE; // (R6)
      end
   end

   // readable copy holds the last completed interval
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         snapshot <= '0;
      end
      else if (update)
      begin
         snapshot <= accum_reg; // (R3) (R4) (R16)
      end
   end
endmodule

// File: tecm_error_monitor.sv
`timescale 1ns/1ns
// Behaviour
// (R1) alarm mask bits gate alarm status sources
// (R2) event mask bits gate event status sources
// (R3) counters update together on timer tick
// (R4) readable counts hold previous interval, stable
// (R5) host reads counts within one interval
// (R6) counters saturate at all ones
// (R7) line count sixteen bits, high then low
// (R8) line count runs even during sync loss
// (R9) b8zs code words not counted when enabled
// (R10) zero runs of 16 or 8 counted
// (R11) esf mode counts crc6 errors
// (R12) d4 counts ft, optionally fs errors
// (R13) path count frozen during sync loss
// (R14) path count split nibble plus byte
// (R15) interrupt when any enabled flag set
// (R16) accumulators transfer atomically, restart at zero
module tecm_error_monitor
   import tecm_pkg::*;
#(
   parameter int LINE_WIDTH = TECM_LINE_WIDTH,
   parameter int PATH_WIDTH = TECM_PATH_WIDTH
)
(
   input wire logic clk,
   input wire logic srst,
   // parallel control port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // status flags, alarm group msb first
   input wire logic [7:0] alarm_status,
   input wire logic [7:0] event_status,
   output logic irq_n,
   // status timer: pulse of either cadence
   input wire logic second_timer_tick,
   input wire logic fast_timer_tick,
   // configuration bits
   input wire logic interval_select,
   input wire logic rx_b8zs_enable,
   input wire logic excess_zero_count_enable,
   input wire logic esf_framing_select,
   input wire logic fs_error_count_enable,
   input wire logic rx_sync_loss,
   // received line events, one per bit time
   input wire logic bit_strobe,
   input wire logic rx_mark,
   input wire logic bipolar_violation,
   input wire logic b8zs_code_word,
   input wire logic crc6_error,
   input wire logic ft_error,
   input wire logic fs_error,
   // upper nibble of shared path register, from out-of-sync counter
   input wire logic [3:0] mos_high_nibble,
   output logic second_timer_flag
);
   logic [7:0] alarm_irq_mask_reg; // alarm group enables
   logic [7:0] event_irq_mask_reg; // event group enables
   logic [4:0] zero_run_reg; // consecutive zeros seen
   logic update; // snapshot strobe
   logic zero_hit; // run reached threshold this bit
   logic line_event; // one line code violation
   logic path_event; // one path violation
   logic [LINE_WIDTH-1:0] line_count; // frozen line count
   logic [PATH_WIDTH-1:0] path_count; // frozen path count
   logic [4:0] zero_limit; // threshold for the current coding
   logic [7:0] alarm_pending; // alarm sources passing their mask
   logic [7:0] event_pending; // event sources passing their mask
   logic [15:0] line_word; // line count at register-pair width
   logic [11:0] path_word; // path count at register-pair width
   logic [7:0] rd_next; // byte handed out at the next read strobe

   // register map selections, shared by the write and read decode
   // none covers every address the block does not own
   typedef enum logic [2:0] {TECM_SEL_NONE, TECM_SEL_LINE_HIGH, TECM_SEL_LINE_LOW, TECM_SEL_PATH_HIGH,
      TECM_SEL_PATH_LOW, TECM_SEL_EVENT_MASK, TECM_SEL_ALARM_MASK} tecm_sel_type;

   // one decoder for both paths, so a write can never land
   // where a read does not look
   function automatic tecm_sel_type decode_addr(input logic [7:0] a);
      tecm_sel_type sel;
      if (a == TECM_ADDR_LINE_HIGH)
      begin
         sel = TECM_SEL_LINE_HIGH;
      end
      else if (a == TECM_ADDR_LINE_LOW)
      begin
         sel = TECM_SEL_LINE_LOW;
      end
      else if (a == TECM_ADDR_PATH_HIGH)
      begin
         sel = TECM_SEL_PATH_HIGH;
      end
      else if (a == TECM_ADDR_PATH_LOW)
      begin
         sel = TECM_SEL_PATH_LOW;
      end
      else if (a == TECM_ADDR_EVENT_MASK)
      begin
         sel = TECM_SEL_EVENT_MASK;
      end
      else if (a == TECM_ADDR_ALARM_MASK)
      begin
         sel = TECM_SEL_ALARM_MASK;
      end
      else
      begin
         sel = TECM_SEL_NONE;
      end
      return sel;
   endfunction

   tecm_sel_type addr_sel; // decoded register selection
   assign addr_sel = decode_addr(addr);

   // pick the tick of the selected cadence; both counters share this one strobe,
   // so line and path snapshots always describe the same interval
   always_comb
   begin
      if (tecm_interval_type'(interval_select) == TECM_FAST_42MS)
      begin
         update = fast_timer_tick; // (R3)
      end
      else
      begin
         update = second_timer_tick; // (R3)
      end
   end

   // tick also drives the second timer status as the host cue
   assign second_timer_flag = update; // (R5)

   // mask registers written by the host; counts are read-only,
   // so a write anywhere else is dropped
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         alarm_irq_mask_reg <= TECM_MASK_RESET;
         event_irq_mask_reg <= TECM_MASK_RESET;
      end
      else if (wr_en)
      begin
         if (addr_sel == TECM_SEL_ALARM_MASK)
         begin
            alarm_irq_mask_reg <= wr_data; // (R1)
         end
         else if (addr_sel == TECM_SEL_EVENT_MASK)
         begin
            event_irq_mask_reg <= wr_data; // (R2)
         end
      end
   end

   // each source passes only while its mask bit is one
   genvar src;
   generate
      for (src = 0; src < 8; src = src + 1)
      begin : g_gate
         assign alarm_pending[src] = alarm_status[src] && alarm_irq_mask_reg[src]; // (R1)
         assign event_pending[src] = event_status[src] && event_irq_mask_reg[src]; // (R2)
      end
   endgenerate

   // active-low request, combinational by choice; it follows the flags with no
   // latency, so a flag that clears also drops the request in the same cycle
   assign irq_n = !(|alarm_pending || |event_pending); // (R15)

   // excessive zero threshold depends on line coding
   assign zero_limit = rx_b8zs_enable ? TECM_ZERO_RUN_B8ZS : TECM_ZERO_RUN_PLAIN; // (R10)
   // at-or-above rather than equal: a coding switch in mid-run lowers the limit
   // under the run already seen, and the run must not climb past it and wrap
   assign zero_hit = bit_strobe && !rx_mark && (zero_run_reg + 5'h01 >= zero_limit); // (R10)

   // zero run tracker; restarts after each counted run
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         zero_run_reg <= 5'h00;
      end
      else if (bit_strobe)
      begin
         if (rx_mark || zero_hit)
         begin
            zero_run_reg <= 5'h00;
         end
         else
         begin
            zero_run_reg <= zero_run_reg + 5'h01;
         end
      end
   end

   // line events ignore sync state on purpose; a bit that is both a violation
   // and the end of a zero run is one event, not two
   always_comb
   begin
      line_event = 1'h0;
      if (bit_strobe)
      begin
         if (bipolar_violation && !(rx_b8zs_enable && b8zs_code_word))
         begin
            line_event = 1'h1; // (R8) (R9)
         end
         if (excess_zero_count_enable && zero_hit)
         begin
            line_event = 1'h1; // (R10)
         end
      end
   end

   // path events follow framing mode, frozen out of sync
   always_comb
   begin
      if (rx_sync_loss)
      begin
         path_event = 1'h0; // (R13)
      end
      else if (esf_framing_select)
      begin
         path_event = crc6_error; // (R11)
      end
      else
      begin
         path_event = ft_error || (fs_error_count_enable && fs_error); // (R12)
      end
   end

   // line code violation accumulator; at the worst error rate the full
   // sixteen bits only just hold one fast 42 ms interval, so saturation rarely shows
   tecm_sat_counter #(.WIDTH(LINE_WIDTH)) line_counter
   (
      .clk(clk),
      .srst(srst),
      .count_en(line_event),
      .update(update),
      .snapshot(line_count)
   );

   // path violation accumulator; twelve bits, sharing its high register
   // with the out-of-sync count kept elsewhere
   tecm_sat_counter #(.WIDTH(PATH_WIDTH)) path_counter
   (
      .clk(clk),
      .srst(srst),
      .count_en(path_event),
      .update(update),
      .snapshot(path_count)
   );

   // size each count to its register pair on purpose
   assign line_word = 16'(line_count); // (R7)
   assign path_word = 12'(path_count); // (R14)

   // read byte from the shared decode; counts and masks only, the rest reads zero
   always_comb
   begin
      if (addr_sel == TECM_SEL_LINE_HIGH)
      begin
         rd_next = line_word[15:8]; // (R7)
      end
      else if (addr_sel == TECM_SEL_LINE_LOW)
      begin
         rd_next = line_word[7:0]; // (R7)
      end
      else if (addr_sel == TECM_SEL_PATH_HIGH)
      begin
         rd_next = {mos_high_nibble, path_word[11:8]}; // (R14)
      end
      else if (addr_sel == TECM_SEL_PATH_LOW)
      begin
         rd_next = path_word[7:0]; // (R14)
      end
      else if (addr_sel == TECM_SEL_EVENT_MASK)
      begin
         rd_next = event_irq_mask_reg; // (R2)
      end
      else if (addr_sel == TECM_SEL_ALARM_MASK)
      begin
         rd_next = alarm_irq_mask_reg; // (R1)
      end
      else
      begin
         rd_next = 8'h00; // unmapped address
      end
   end

   // registered read port; the two bytes of a count are not latched together,
   // which is safe only because the snapshot stands still for the whole interval
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_data <= 8'h00;
      end
      else if (rd_en)
      begin
         rd_data <= rd_next; // (R4)
      end
   end
endmodule

// File: tecm_chk.sv
`timescale 1ns/1ns
// port-level watch on the control port, irq gating and readback
module tecm_chk
   import tecm_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] alarm_status,
   input wire logic [7:0] event_status,
   input wire logic irq_n,
   input wire logic second_timer_tick,
   input wire logic fast_timer_tick,
   input wire logic interval_select,
   input wire logic second_timer_flag
);
   logic [7:0] am_reg; // shadow masks, so gating can be judged
   logic [7:0] em_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // shadow follows host writes
   always_ff @(posedge clk)
   begin
      if (srst)
         {am_reg, em_reg} <= {TECM_MASK_RESET, TECM_MASK_RESET};
      else if (wr_en && addr == TECM_ADDR_ALARM_MASK)
         am_reg <= wr_data;
      else if (wr_en && addr == TECM_ADDR_EVENT_MASK)
         em_reg <= wr_data;
   end
   sequence rd_at(a);
      rd_en && addr == a;
   endsequence
   alarm_gate_a: assert property (|(alarm_status & am_reg) |-> !irq_n) else $error("alarm");
   event_gate_a: assert property (|(event_status & em_reg) |-> !irq_n) else $error("event");
   irq_quiet_a: assert property (!(|{alarm_status & am_reg, event_status & em_reg}) |-> irq_n) else $error("irq");
   timer_sel_a: assert property (second_timer_flag == (interval_select ? fast_timer_tick : second_timer_tick))
      else $error("timer");
   mask_back_a: assert property (rd_at(TECM_ADDR_ALARM_MASK) |=> rd_data == $past(am_reg)) else $error("mask");
   event_back_a: assert property (rd_at(TECM_ADDR_EVENT_MASK) |=> rd_data == $past(em_reg)) else $error("emask");
   read_hold_a: assert property (!rd_en |=> $stable(rd_data)) else $error("hold");
   unmapped_read_a: assert property (rd_at(8'h20) |=> rd_data == 8'h00) else $error("unmapped");
   reset_value_a: assert property ($fell(srst) |-> rd_data == 8'h00 && irq_n) else $error("reset");
endmodule
bind tecm_error_monitor tecm_chk u_chk (.clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .alarm_status,
   .event_status, .irq_n, .second_timer_tick, .fast_timer_tick, .interval_select, .second_timer_flag);

// File: tecm_host.sv
`timescale 1ns/1ns
// host on the control port; address parked inverted when idle
module tecm_host
(
   input wire logic clk,
   output logic [7:0] addr = 8'h00,
   output logic [7:0] wr_data = 8'h00,
   output logic wr_en = 1'h0,
   output logic rd_en = 1'h0
);
   // one access, strobe held through one sampling edge
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      {wr_en, rd_en} <= {w, !w};
      @(posedge clk);
      {wr_en, rd_en} <= 2'h0;
      addr <= ~a;
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module testbench
   import tecm_pkg::*;
   ;
   logic clk = 1'h0, srst = 1'h1, act = 1'h0, tk = 1'h0, mk = 1'h0, rd_q = 1'h0, irq_n, stf, wr_en, rd_en;
   logic [5:0] cfg = 6'h00; // timer sel, b8zs, zeros, esf, fs, sync loss
   logic [4:0] ev = 5'h00; // bpv, code word, crc, ft, fs
   logic [7:0] am, em, ex, ast = 8'h00, est = 8'h00, addr, wr_data, rd_data;
   logic [3:0] mos = 4'h0;
   logic [7:0] exp_q[$];
   int err_total = 0, tests_run = 0;
   initial forever #2 clk = ~clk;
   tecm_host u_host (.clk, .addr, .wr_data, .wr_en, .rd_en);
   // unselected tick pulses during bursts, so a wrong timer choice shows
   tecm_error_monitor u_dut (.clk, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .alarm_status(ast),
      .event_status(est), .irq_n, .second_timer_tick(cfg[5] ? act : tk), .fast_timer_tick(cfg[5] ? tk : act),
      .interval_select(cfg[5]), .rx_b8zs_enable(cfg[4]), .excess_zero_count_enable(cfg[3]),
      .esf_framing_select(cfg[2]), .fs_error_count_enable(cfg[1]), .rx_sync_loss(cfg[0]), .bit_strobe(act),
      .rx_mark(act & mk), .bipolar_violation(act & ev[4]), .b8zs_code_word(act & ev[3]),
      .crc6_error(act & ev[2]), .ft_error(act & ev[1]), .fs_error(act & ev[0]), .mos_high_nibble(mos),
      .second_timer_flag(stf));
   // read result is due on the edge after the strobe
   always @(posedge clk)
   begin
      rd_q <= rd_en;
      if (rd_q)
      begin
         ex = exp_q.pop_front();
         `CHK("rd_data", ex, rd_data)
      end
   end
   task automatic rd_x(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      u_host.acc(a, 8'h00, 1'h0);
   endtask
   // burst of n events, then one tick, then read all counts
   task automatic run(input logic [5:0] c, input logic [4:0] e, input logic m, input int n,
      input logic [15:0] le, input logic [11:0] pe);
      @(posedge clk);
      {cfg, ev, mk, act} <= {c, e, m, 1'h1};
      repeat (n) @(posedge clk);
      `CHK("second_timer_flag", 1'h0, stf)
      act <= 1'h0;
      @(posedge clk);
      tk <= 1'h1;
      @(posedge clk);
      `CHK("second_timer_flag", 1'h1, stf)
      tk <= 1'h0;
      rd_x(TECM_ADDR_LINE_HIGH, le[15:8]);
      rd_x(TECM_ADDR_LINE_LOW, le[7:0]);
      rd_x(TECM_ADDR_PATH_HIGH, {mos, pe[11:8]});
      rd_x(TECM_ADDR_PATH_LOW, pe[7:0]);
   endtask
   task automatic end_of_test();
      err_total += exp_q.size();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h48CC));
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      am = 8'($urandom);
      em = 8'($urandom);
      {ast, est, mos} <= 20'($urandom);
      u_host.acc(TECM_ADDR_ALARM_MASK, am, 1'h1);
      u_host.acc(TECM_ADDR_EVENT_MASK, em, 1'h1);
      rd_x(TECM_ADDR_ALARM_MASK, am);
      rd_x(TECM_ADDR_EVENT_MASK, em);
      rd_x(8'h20, 8'h00);
      // one source at a time through each group against the random masks
      for (int i = 0; i < 8; i++)
      begin
         {ast, est} <= {8'h01 << i, 8'h00};
         repeat (2) @(posedge clk);
         `CHK("irq_n", !am[i], irq_n)
         {ast, est} <= {8'h00, 8'h01 << i};
         repeat (2) @(posedge clk);
         `CHK("irq_n", !em[i], irq_n)
      end
      run(6'h04, 5'h14, 1'h1, 5, 16'h0005, 12'h005);
      run(6'h05, 5'h14, 1'h1, 7, 16'h0007, 12'h000);
      run(6'h30, 5'h18, 1'h1, 6, 16'h0000, 12'h000);
      run(6'h00, 5'h03, 1'h1, 4, 16'h0000, 12'h004);
      run(6'h02, 5'h01, 1'h1, 3, 16'h0000, 12'h003);
      run(6'h08, 5'h00, 1'h0, 32, 16'h0002, 12'h000);
      run(6'h18, 5'h00, 1'h0, 24, 16'h0003, 12'h000);
      run(6'h04, 5'h14, 1'h1, 4100, 16'h1004, 12'hFFF);
      // more events but no tick: the frozen counts must not move
      act <= 1'h1;
      repeat (3) @(posedge clk);
      act <= 1'h0;
      rd_x(TECM_ADDR_LINE_LOW, 8'h04);
      rd_x(TECM_ADDR_PATH_LOW, 8'hFF);
      // let the last read reach the comparing process
      repeat (3) @(posedge clk);
      end_of_test();
   end
   // hang guard, well past the expected run time
   initial
   begin
      #100000;
      err_total++;
      end_of_test();
   end
endmodule
